// *** fifo_read_port.sv ***
// Read port, almost-full flag and reset handling of a dual-clock FIFO

module pin_sync #(
  parameter int   W         = 1,
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] stable
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Change counts once second and third stage agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1     <= {W{RESET_VAL}};
      s2     <= {W{RESET_VAL}};
      s3     <= {W{RESET_VAL}};
      stable <= {W{RESET_VAL}};
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        stable <= s3;
      end
    end
  end
endmodule

module fifo_async #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input  wire logic                       writeClock,
  input  wire logic                       readClock,
  input  wire logic                       arst_n,
  input  wire logic                       writeClear,
  input  wire logic [WIDTH-1:0]           writeData,
  input  wire logic                       writeValid,
  output logic                            writeReady,
  output logic [$clog2(DEPTH):0]          writeCount,
  input  wire logic                       readClear,
  output logic [WIDTH-1:0]                readData,
  output logic                            readValid,
  input  wire logic                       readReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wBin;
  logic [AW:0]      wGray;
  logic [AW:0]      rBin;
  logic [AW:0]      rGray;
  logic [AW:0]      rGray1;
  logic [AW:0]      rGray2;
  logic [AW:0]      wGray1;
  logic [AW:0]      wGray2;
  logic [AW:0]      next_wBin;
  logic [AW:0]      next_wGray;
  logic [AW:0]      next_rBin;
  logic [AW:0]      next_rGray;
  logic             doWrite;
  logic             doRead;

  function automatic logic [AW:0] grayToBin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  assign doWrite    = writeValid && writeReady;
  assign doRead     = readValid && readReady;
  assign next_wBin  = wBin + {{AW{1'b0}}, doWrite};
  assign next_wGray = (next_wBin >> 1) ^ next_wBin;
  assign next_rBin  = rBin + {{AW{1'b0}}, doRead};
  assign next_rGray = (next_rBin >> 1) ^ next_rBin;
  assign readData   = mem[rBin[AW-1:0]];

  // Storage array
  always_ff @(posedge writeClock) begin
    if (doWrite) begin
      mem[wBin[AW-1:0]] <= writeData;
    end
  end

  // Write pointer, full and count
  always_ff @(posedge writeClock or negedge arst_n) begin
    if (!arst_n) begin
      wBin       <= '0;
      wGray      <= '0;
      rGray1     <= '0;
      rGray2     <= '0;
      writeReady <= 1'b1;
      writeCount <= '0;
    end else if (writeClear) begin
      wBin       <= '0;
      wGray      <= '0;
      rGray1     <= '0;
      rGray2     <= '0;
      writeReady <= 1'b1;
      writeCount <= '0;
    end else begin
      rGray1     <= rGray;
      rGray2     <= rGray1;
      wBin       <= next_wBin;
      wGray      <= next_wGray;
      writeReady <= next_wGray !=
                    {~rGray2[AW:AW-1], rGray2[AW-2:0]};
      writeCount <= next_wBin - grayToBin(rGray2);
    end
  end

  // Read pointer and empty
  always_ff @(posedge readClock or negedge arst_n) begin
    if (!arst_n) begin
      rBin      <= '0;
      rGray     <= '0;
      wGray1    <= '0;
      wGray2    <= '0;
      readValid <= 1'b0;
    end else if (readClear) begin
      rBin      <= '0;
      rGray     <= '0;
      wGray1    <= '0;
      wGray2    <= '0;
      readValid <= 1'b0;
    end else begin
      wGray1    <= wGray;
      wGray2    <= wGray1;
      rBin      <= next_rBin;
      rGray     <= next_rGray;
      readValid <= next_rGray != wGray2;
    end
  end
endmodule

module fifo_read_port
  import fifo_read_pkg::*;
#(
  parameter int DW    = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int OW    = $clog2(FIFO_DEPTH) + 1
) (
  input  wire logic          clock,
  input  wire logic          arst_n,
  input  wire logic          readClock,
  input  wire logic [DW-1:0] writeData,
  input  wire logic          writeValid,
  output logic               writeReady,
  input  wire logic [OW-1:0] fullOffsetIn,
  input  wire logic          fullOffsetLoad,
  input  wire logic          flag_timing_select,
  input  wire logic          first_word_fall_through_mode,
  input  wire logic          partial_reset_n,
  input  wire logic          readEnable_n,
  input  wire logic          readStrobe,
  input  wire logic          readAsyncMode,
  input  wire logic          read_select_n,
  input  wire logic          offset_load_n,
  input  wire logic          output_enable_n,
  input  wire logic [1:0]    outputWidth,
  output logic [DW-1:0]      read_data_out,
  output logic               readDataOe,
  output logic               almost_full_flag_n,
  output logic               flagSyncMode,
  output logic               fwftModeStatus
);
  localparam logic [OW-1:0] DEPTH_W = OW'(DEPTH);

  // Write-domain signals
  logic          prsW;
  logic          timSelS;
  logic          fwftS;
  logic [2:0]    strapCount;
  logic [OW-1:0] fullOffset;
  logic [OW-1:0] wordCount;
  logic [OW-1:0] freeCount;
  logic          flagNow;
  logic          flagStage;

  // Read-domain signals
  logic          prsR;
  logic          renN;
  logic          selN;
  logic          ldN;
  logic          strobeS;
  logic          strobePrev;
  logic          asyncS;
  logic          oeN;
  logic [1:0]    widthS;
  logic [OW-1:0] offsetR;
  logic [DW-1:0] headWord;
  logic          headValid;
  logic [DW-1:0] holdWord;
  logic [1:0]    lane;
  logic [1:0]    laneLast;
  logic          readEvent;
  logic          pop;

  pin_sync #(.W(1), .RESET_VAL(1'b1)) uPrsW (
    .clock(clock), .arst_n(arst_n), .pinIn(partial_reset_n),
    .stable(prsW));
  pin_sync #(.W(1), .RESET_VAL(1'b0)) uTim (
    .clock(clock), .arst_n(arst_n), .pinIn(flag_timing_select),
    .stable(timSelS));
  pin_sync #(.W(1), .RESET_VAL(1'b0)) uFwft (
    .clock(clock), .arst_n(arst_n),
    .pinIn(first_word_fall_through_mode), .stable(fwftS));

  pin_sync #(.W(1), .RESET_VAL(1'b1)) uPrsR (
    .clock(readClock), .arst_n(arst_n), .pinIn(partial_reset_n),
    .stable(prsR));
  pin_sync #(.W(1), .RESET_VAL(1'b1)) uRen (
    .clock(readClock), .arst_n(arst_n), .pinIn(readEnable_n),
    .stable(renN));
  pin_sync #(.W(1), .RESET_VAL(1'b1)) uSel (
    .clock(readClock), .arst_n(arst_n), .pinIn(read_select_n),
    .stable(selN));
  pin_sync #(.W(1), .RESET_VAL(1'b1)) uLd (
    .clock(readClock), .arst_n(arst_n), .pinIn(offset_load_n),
    .stable(ldN));
  pin_sync #(.W(1), .RESET_VAL(1'b0)) uStb (
    .clock(readClock), .arst_n(arst_n), .pinIn(readStrobe),
    .stable(strobeS));
  pin_sync #(.W(1), .RESET_VAL(1'b0)) uAsy (
    .clock(readClock), .arst_n(arst_n), .pinIn(readAsyncMode),
    .stable(asyncS));
  pin_sync #(.W(1), .RESET_VAL(1'b1)) uOe (
    .clock(readClock), .arst_n(arst_n), .pinIn(output_enable_n),
    .stable(oeN));
  pin_sync #(.W(2), .RESET_VAL(1'b0)) uWid (
    .clock(readClock), .arst_n(arst_n), .pinIn(outputWidth),
    .stable(widthS));
  pin_sync #(.W(OW), .RESET_VAL(1'b0)) uOfs (
    .clock(readClock), .arst_n(arst_n), .pinIn(fullOffset),
    .stable(offsetR));

  fifo_async #(.WIDTH(DW), .DEPTH(DEPTH)) uFifo (
    .writeClock(clock),
    .readClock(readClock),
    .arst_n(arst_n),
    .writeClear(!prsW),
    .writeData(writeData),
    .writeValid(writeValid),
    .writeReady(writeReady),
    .writeCount(wordCount),
    .readClear(!prsR),
    .readData(headWord),
    .readValid(headValid),
    .readReady(pop)
  );

  // Mode straps caught once after master reset release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strapCount     <= 3'h0;
      flagSyncMode   <= 1'b0;
      fwftModeStatus <= 1'b0;
    end else if (strapCount != STRAP_WAIT) begin
      strapCount <= strapCount + 3'h1;
      if (strapCount + 3'h1 == STRAP_WAIT) begin
        flagSyncMode   <= timSelS;
        fwftModeStatus <= fwftS;
      end
    end
  end

  // Full offset register, kept over partial reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fullOffset <= FULL_OFFSET_RST[OW-1:0];
    end else if (fullOffsetLoad) begin
      fullOffset <= fullOffsetIn;
    end
  end

  assign freeCount = DEPTH_W - wordCount;
  assign flagNow   = freeCount > fullOffset;

  // Almost-full flag, one extra stage in synchronous timing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flagStage          <= 1'b1;
      almost_full_flag_n <= 1'b1;
    end else begin
      flagStage <= flagNow;
      if (flagSyncMode) begin
        almost_full_flag_n <= flagStage;
      end else begin
        almost_full_flag_n <= flagNow;
      end
    end
  end

  // Read requests from clock enable or strobe edge
  always_ff @(posedge readClock or negedge arst_n) begin
    if (!arst_n) begin
      strobePrev <= 1'b0;
    end else begin
      strobePrev <= strobeS;
    end
  end

  assign readEvent = prsR && !selN &&
                     (asyncS ? (strobeS && !strobePrev)
                             : !renN);

  always_comb begin
    case (bus_width_t'(widthS))
      BUS_X18: laneLast = LANE_LAST_X18;
      BUS_X9:  laneLast = LANE_LAST_X9;
      default: laneLast = LANE_LAST_X36;
    endcase
  end

  assign pop = readEvent && ldN && lane == 2'h0 && headValid;

  function automatic logic [DW-1:0] piece(input logic [DW-1:0] w,
                                          input logic [1:0] l,
                                          input logic [1:0] ws);
    logic [DW-1:0] r;
    r = '0;
    case (bus_width_t'(ws))
      BUS_X18: r[HALF_W-1:0] = w[l[0]*HALF_W +: HALF_W];
      BUS_X9:  r[BYTE_W-1:0] = w[l*BYTE_W +: BYTE_W];
      default: r = w;
    endcase
    return r;
  endfunction

  // Output register and lane position
  always_ff @(posedge readClock or negedge arst_n) begin
    if (!arst_n) begin
      read_data_out <= '0;
      holdWord      <= '0;
      lane          <= 2'h0;
    end else if (!prsR) begin
      read_data_out <= '0;
      holdWord      <= '0;
      lane          <= 2'h0;
    end else if (readEvent) begin
      if (!ldN) begin
        read_data_out <= {{(DW-OW){1'b0}}, offsetR};
      end else if (lane == 2'h0) begin
        if (headValid) begin
          holdWord      <= headWord;
          read_data_out <= piece(headWord, 2'h0, widthS);
          lane          <= (laneLast == 2'h0) ? 2'h0 : 2'h1;
        end
      end else begin
        read_data_out <= piece(holdWord, lane, widthS);
        lane          <= (lane == laneLast) ? 2'h0 : lane + 2'h1;
      end
    end
  end

  // Output drive control
  always_ff @(posedge readClock or negedge arst_n) begin
    if (!arst_n) begin
      readDataOe <= 1'b0;
    end else if (!prsR) begin
      readDataOe <= !oeN;
    end else begin
      readDataOe <= !oeN && !selN;
    end
  end
endmodule

// *** fifo_read_pkg.sv ***
// Shared constants for the read-side FIFO block
package fifo_read_pkg;
  localparam int          DATA_W          = 36;
  localparam int          FIFO_DEPTH      = 32;
  localparam int          HALF_W          = 18;
  localparam int          BYTE_W          = 9;
  localparam logic [5:0]  FULL_OFFSET_RST = 6'h08;
  localparam logic [2:0]  STRAP_WAIT      = 3'h5;
  localparam logic [1:0]  LANE_LAST_X36   = 2'h0;
  localparam logic [1:0]  LANE_LAST_X18   = 2'h1;
  localparam logic [1:0]  LANE_LAST_X9    = 2'h3;
  typedef enum logic [1:0] {BUS_X36, BUS_X18, BUS_X9} bus_width_t;
endpackage

// *** fifo_read_port_asserts.sv ***
// Concurrent checks on the read port top-level ports
module fifo_read_port_asserts #(
  parameter int DW = 36,
  parameter int OW = 6
) (
  input wire logic          clock,
  input wire logic          arst_n,
  input wire logic          readClock,
  input wire logic          writeReady,
  input wire logic [OW-1:0] fullOffsetIn,
  input wire logic          fullOffsetLoad,
  input wire logic          partial_reset_n,
  input wire logic          read_select_n,
  input wire logic          output_enable_n,
  input wire logic [1:0]    outputWidth,
  input wire logic [DW-1:0] read_data_out,
  input wire logic          readDataOe,
  input wire logic          almost_full_flag_n,
  input wire logic          flagSyncMode,
  input wire logic          fwftModeStatus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] age;

  // Cycles since reset release, saturating
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      age <= 4'h0;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end

  a_full_flag_low: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!writeReady && partial_reset_n) [*8] |-> !almost_full_flag_n)
    else $error("flag high while full");
  a_offset_flag: assert property (
    @(posedge clock) disable iff (!arst_n)
    fullOffsetLoad && fullOffsetIn == OW'(32) |-> ##[1:4] !almost_full_flag_n)
    else $error("flag high with full-size offset");
  a_straps_kept: assert property (
    @(posedge clock) disable iff (!arst_n)
    age == 4'hf |-> $stable(flagSyncMode) && $stable(fwftModeStatus))
    else $error("strap status changed");
  a_narrow_upper: assert property (
    @(posedge readClock) disable iff (!arst_n)
    (outputWidth == 2'h2) [*8] ##0 $changed(read_data_out)
    |-> read_data_out[DW-1:9] == '0)
    else $error("upper lines set in narrow mode");
  a_oe_off: assert property (
    @(posedge readClock) disable iff (!arst_n)
    output_enable_n [*8] |-> !readDataOe)
    else $error("driven while output disabled");
  a_select_off: assert property (
    @(posedge readClock) disable iff (!arst_n)
    (read_select_n && partial_reset_n) [*8] |-> !readDataOe)
    else $error("driven while deselected");
  a_reset_drive: assert property (
    @(posedge readClock) disable iff (!arst_n)
    (!partial_reset_n && !output_enable_n) [*8] |-> readDataOe)
    else $error("not driven in partial reset");
  a_prs_clear: assert property (
    @(posedge readClock) disable iff (!arst_n)
    !partial_reset_n [*8] |-> read_data_out == '0)
    else $error("data kept in partial reset");
endmodule

// *** fifo_reader_model.sv ***
// Reading party: drives read enable, strobe and read mode
module fifo_reader_model (
  input wire logic readClock,
  output logic     readEnable_n,
  output logic     readStrobe,
  output logic     readAsyncMode
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    readEnable_n  = 1'b1;
    readStrobe    = 1'b0;
    readAsyncMode = 1'b0;
  end

  // Strobe mode keeps read enable at its active level
  task automatic setMode(input logic strobe);
    @(posedge readClock);
    readAsyncMode <= strobe;
    readEnable_n  <= !strobe;
    repeat (8) @(posedge readClock);
  endtask

  // One strobe rise, or n enabled clock edges
  // Enable held one cycle only is dropped by the pin filter
  task automatic readWords(input int n);
    @(posedge readClock);
    if (readAsyncMode) begin
      readStrobe <= 1'b1;
      repeat (3) @(posedge readClock);
      readStrobe <= 1'b0;
    end else begin
      readEnable_n <= 1'b0;
      repeat (n) @(posedge readClock);
      readEnable_n <= 1'b1;
    end
    repeat (10) @(posedge readClock);
  endtask
endmodule

// *** fifo_read_port_tb.sv ***
// Self-checking bench for the FIFO read port
module fifo_read_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fifo_read_pkg::*;
  logic        clock, readClock, arst_n, writeValid, writeReady;
  logic        fullOffsetLoad, flag_timing_select;
  logic        first_word_fall_through_mode;
  logic        partial_reset_n, read_select_n, offset_load_n, output_enable_n;
  logic        readEnable_n, readStrobe, readAsyncMode, readDataOe;
  logic        almost_full_flag_n, flagSyncMode, fwftModeStatus;
  logic [1:0]  outputWidth;
  logic [5:0]  fullOffsetIn;
  logic [35:0] writeData, read_data_out;
  int          fails, compares, wrCount;

  fifo_read_port dut (.*);
  fifo_reader_model reader (.*);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    readClock = 1'b0;
    #17;
    forever #62.5 readClock = ~readClock;
  end

  function automatic logic [35:0] word(input int i);
    return 36'h0a5a5a500 + 36'(i);
  endfunction

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pushWords(input int n);
    for (int i = 0; i < n; i++) begin
      writeValid <= 1'b1;
      writeData  <= word(wrCount);
      wrCount++;
      @(posedge clock);
    end
    writeValid <= 1'b0;
    repeat (12) @(posedge clock);
  endtask

  task automatic loadOffset(input logic [5:0] v);
    fullOffsetIn   <= v;
    fullOffsetLoad <= 1'b1;
    @(posedge clock);
    fullOffsetLoad <= 1'b0;
    repeat (6) @(posedge clock);
  endtask

  // One word, flag looked at two edges after it is taken
  task automatic pushOneTimed(input logic [35:0] exp);
    writeValid <= 1'b1;
    writeData  <= word(wrCount);
    wrCount++;
    @(posedge clock);
    writeValid <= 1'b0;
    repeat (2) @(posedge clock);
    check(36'(almost_full_flag_n), exp);
    repeat (10) @(posedge clock);
  endtask

  task automatic rd(input int n);
    reader.readWords(n);
    @(posedge clock);
  endtask

  task automatic testReset;
    check(36'(writeReady), 36'h1);
    check(36'(almost_full_flag_n), 36'h1);
    check(read_data_out, 36'h0);
    check(36'(readDataOe), 36'h0);
    check(36'({flagSyncMode, fwftModeStatus}), 36'h3);
    $display("reset test done");
  endtask

  task automatic testFlag;
    pushWords(23);
    check(36'(almost_full_flag_n), 36'h1);
    pushOneTimed(36'h1);
    check(36'(almost_full_flag_n), 36'h0);
    loadOffset(6'h07);
    check(36'(almost_full_flag_n), 36'h1);
    loadOffset(6'h20);
    loadOffset(FULL_OFFSET_RST);
    pushWords(8);
    check(36'({writeReady, almost_full_flag_n}), 36'h0);
    $display("flag test done");
  endtask

  task automatic testRead;
    read_select_n   <= 1'b0;
    output_enable_n <= 1'b0;
    rd(2);
    check(read_data_out, word(1));
    check(36'(readDataOe), 36'h1);
    offset_load_n <= 1'b0;
    rd(2);
    check(read_data_out, 36'(FULL_OFFSET_RST));
    offset_load_n <= 1'b1;
    rd(2);
    check(read_data_out, word(3));
    reader.setMode(1'b1);
    rd(1);
    check(read_data_out, word(4));
    reader.setMode(1'b0);
    $display("read test done");
  endtask

  task automatic testSelect;
    read_select_n <= 1'b1;
    rd(2);
    check(read_data_out, word(4));
    check(36'(readDataOe), 36'h0);
    read_select_n <= 1'b0;
    outputWidth   <= 2'h2;
    rd(2);
    check(read_data_out, (word(5) >> 9) & 36'h1ff);
    rd(2);
    check(read_data_out, word(5) >> 27);
    outputWidth   <= 2'h1;
    rd(2);
    check(read_data_out, word(6) >> 18);
    $display("select test done");
  endtask

  task automatic testPartial;
    read_select_n   <= 1'b1;
    partial_reset_n <= 1'b0;
    repeat (100) @(posedge clock);
    check(read_data_out, 36'h0);
    check(36'(readDataOe), 36'h1);
    check(36'(flagSyncMode), 36'h1);
    partial_reset_n <= 1'b1;
    read_select_n   <= 1'b0;
    outputWidth     <= 2'h0;
    repeat (100) @(posedge clock);
    check(36'(almost_full_flag_n), 36'h1);
    rd(2);
    check(read_data_out, 36'h0);
    pushWords(24);
    check(36'(almost_full_flag_n), 36'h0);
    rd(2);
    check(read_data_out, word(33));
    $display("partial reset test done");
  endtask

  // Master reset again with the straps low
  task automatic testStrap;
    flag_timing_select           <= 1'b0;
    first_word_fall_through_mode <= 1'b0;
    arst_n                       <= 1'b0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    check(36'({flagSyncMode, fwftModeStatus}), 36'h0);
    check(36'(almost_full_flag_n), 36'h1);
    pushWords(23);
    pushOneTimed(36'h0);
    $display("strap test done");
  endtask

  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {writeValid, fullOffsetLoad, offset_load_n, partial_reset_n} = 4'h3;
    {read_select_n, output_enable_n, flag_timing_select} = 3'h7;
    first_word_fall_through_mode = 1'b1;
    {outputWidth, fullOffsetIn, writeData} = '0;
    arst_n = 1'b0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    testReset;
    testFlag;
    testRead;
    testSelect;
    testPartial;
    testStrap;
    report_and_stop;
  end
endmodule

bind fifo_read_port fifo_read_port_asserts #(.DW(DW), .OW(OW)) chk (.*);
